/* rtl/lpmcs_core.sv */
// power-mode and system-clock control: peripheral-halt modes and slow/fast switching
`timescale 1ns/1ps
`include "lpmcs_consts.svh"

// What this block and its software must do
// RQ1: halt stops peripheral clocks except time base
// RQ2: halt freezes CPU state and port latches
// RQ3: held program counter is entry address plus two
// RQ4: software stops peripherals before halt entry
// RQ5: writing halt bit one enters halt mode
// RQ6: master, irq enable, time base enable pick release
// RQ7: release clears halt bit, restores prior mode
// RQ8: time base enabled at entry sets latch
// RQ9: entry and exit ignore time base enable
// RQ10: normal release wakes on source falling edge
// RQ11: interrupt release wakes then services time base
// RQ12: reset releases halt, restarts single-clock fast
// RQ13: halt may end early, asynchronous return path
// RQ14: watchdog interrupt just before entry blocks halt
// RQ15: software selects slow clock, then stops oscillator
// RQ16: high-frequency oscillator may run in slow
// RQ17: software stops fast oscillator before stop
// RQ18: software enables oscillator, warms up, clears select
// RQ19: fast switch waits for clock synchronisation
// RQ20: reset releases slow, restarts single-clock fast
// RQ21: clearing both enables gives bounded clock reset
// RQ22: clearing fast enable on fast clock resets
// RQ23: clearing slow enable on slow clock resets
// RQ24: mode and clock source are visible outputs
module lpmcs_core (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // software control
    input wire lpmcs_pkg::lpmcs_sc2_wr_t sc2_wr_i,
    input wire lpmcs_pkg::lpmcs_tb_ctrl_t tb_ctrl_i,
    input wire logic wdt_irq_i,
    input wire logic time_base_latch_clr_i,
    input wire logic [15:0] cpu_pc_i,
    // pins
    input wire logic [7:0] time_base_src_i,
    input wire logic fs_clk_i,
    // clock gating and cpu hold
    output logic periph_clk_en_o,
    output logic time_base_clk_en_o,
    output logic cpu_hold_o,
    output logic [15:0] pc_hold_o,
    // release events and system clock reset
    output logic wake_o,
    output logic resume_next_o,
    output logic time_base_service_o,
    output logic sysclk_rst_o,
    // status
    output lpmcs_pkg::lpmcs_status_t status_o
);
    import lpmcs_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        lpmcs_mode_t mode;
        lpmcs_mode_t pre_mode;
        logic xen;
        logic xten;
        logic sysck;
        logic halt_bit;
        logic sel_low;
        logic il;
        logic irq_rel;
        logic wake;
        logic svc;
        logic resume;
        logic rst_act;
        logic [6:0] rst_cnt;
        logic [15:0] pc_hold;
    } lpmcs_core_st_t;

    localparam lpmcs_core_st_t RESET_ST = '{
        mode: fast_single_clock_mode,
        pre_mode: fast_single_clock_mode,
        xen: `LPMCS_RST_XEN,
        xten: `LPMCS_RST_XTEN,
        sysck: `LPMCS_RST_SYSCK,
        halt_bit: 1'b0,
        sel_low: 1'b0,
        il: 1'b0,
        irq_rel: 1'b0,
        wake: 1'b0,
        svc: 1'b0,
        resume: 1'b0,
        rst_act: 1'b0,
        rst_cnt: 7'h00,
        pc_hold: 16'h0000
    };
    localparam logic [6:0] RST_LAST = 7'(`LPMCS_SYSRST_CYC - 1);

    lpmcs_core_st_t st;
    lpmcs_core_st_t next_st;
    logic [`LPMCS_NSRC-1:0] src_fall;
    logic tb_fall;
    logic fs_fall;
    logic halted;
    logic w_xen;
    logic w_xten;
    logic w_sysck;
    logic w_halt;
    logic clk_fault;
    logic enter;
    logic il_set;

    // mode from oscillator enables and the clock actually in use
    function automatic lpmcs_mode_t run_mode(input logic xen, input logic xten,
                                             input logic low);
        if (low) begin
            run_mode = xen ? slow_hf_on_mode : slow_hf_off_mode;
        end else begin
            run_mode = xten ? fast_dual_clock_mode : fast_single_clock_mode;
        end
    endfunction

    // ==========================================================
    // pin sampling
    lpmcs_pin_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .pin_i({fs_clk_i, time_base_src_i}),
        .fall_o(src_fall)
    );

    // early wake possible: the edge may come any time after entry
    assign tb_fall = src_fall[tb_ctrl_i.time_base_clock_select]; // RQ13
    assign fs_fall = src_fall[`LPMCS_FS_IDX];
    assign halted = st.halt_bit;

    // ==========================================================
    // decode of a software write
    assign w_xen = sc2_wr_i.data[`LPMCS_SC2_XEN];
    assign w_xten = sc2_wr_i.data[`LPMCS_SC2_XTEN];
    assign w_sysck = sc2_wr_i.data[`LPMCS_SC2_SYSCK];
    assign w_halt = sc2_wr_i.data[`LPMCS_SC2_HALT];
    assign clk_fault = sc2_wr_i.wr && !st.rst_act && !halted &&
        ((st.xen && !w_xen && st.xten && !w_xten) || // RQ21
         (st.xen && !w_xen && !st.sysck) || // RQ22
         (st.xten && !w_xten && st.sysck)); // RQ23
    // entry does not look at the time base enable; a watchdog irq blocks it
    assign enter = sc2_wr_i.wr && w_halt && !wdt_irq_i && !clk_fault &&
                   !st.rst_act && !halted; // RQ5 RQ9 RQ14
    assign il_set = enter && tb_ctrl_i.time_base_enable; // RQ8

    // ==========================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.wake = 1'b0;
        next_st.svc = 1'b0;
        next_st.resume = 1'b0;
        if (st.rst_act) begin
            // oscillators keep running; the whole block restarts at the end
            if (st.rst_cnt == RST_LAST) begin
                next_st = RESET_ST; // RQ21
            end else begin
                next_st.rst_cnt = st.rst_cnt + 7'h01;
            end
        end else if (halted) begin
            if (tb_fall) begin
                next_st.halt_bit = 1'b0; // RQ7
                next_st.mode = st.pre_mode; // RQ7
                next_st.wake = 1'b1; // RQ10 RQ11
                next_st.svc = st.irq_rel; // RQ11
                next_st.resume = !st.irq_rel; // RQ10
            end
        end else begin
            // a return to the fast clock waits for a slow clock edge
            if (!st.sysck && st.sel_low && fs_fall) begin
                next_st.sel_low = 1'b0; // RQ19
            end
            if (clk_fault) begin
                next_st.rst_act = 1'b1;
                next_st.rst_cnt = 7'h00;
            end else if (sc2_wr_i.wr) begin
                next_st.xen = w_xen; // RQ16
                next_st.xten = w_xten;
                next_st.sysck = w_sysck;
                if (w_sysck) begin
                    next_st.sel_low = 1'b1;
                end
            end
            next_st.mode = run_mode(next_st.xen, next_st.xten, next_st.sel_low); // RQ24
            if (enter) begin
                next_st.pre_mode = next_st.mode;
                next_st.mode = next_st.sel_low ? peripheral_halt_slow
                                               : peripheral_halt_fast;
                next_st.halt_bit = 1'b1; // RQ5
                next_st.irq_rel = tb_ctrl_i.interrupt_master_flag &
                                  tb_ctrl_i.time_base_irq_enable &
                                  tb_ctrl_i.time_base_enable; // RQ6
                next_st.pc_hold = cpu_pc_i + `LPMCS_PC_STEP; // RQ3
            end
        end
        // a set in the clear cycle wins
        if (il_set) begin
            next_st.il = 1'b1; // RQ8
        end else if (time_base_latch_clr_i && !st.rst_act) begin
            next_st.il = 1'b0;
        end
    end

    // reset pin returns everything to the single-clock fast mode
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st <= RESET_ST; // RQ12 RQ20
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    assign periph_clk_en_o = !halted; // RQ1
    assign time_base_clk_en_o = 1'b1; // RQ1
    assign cpu_hold_o = halted; // RQ2
    assign pc_hold_o = st.pc_hold;
    assign wake_o = st.wake;
    assign resume_next_o = st.resume;
    assign time_base_service_o = st.svc;
    assign sysclk_rst_o = st.rst_act;
    assign status_o = '{
        mode: st.mode,
        sys_clk_low: st.sel_low,
        hf_osc_en: st.xen,
        lf_osc_en: st.xten,
        timing_generator_halt: st.halt_bit,
        time_base_interrupt: st.il
    }; // RQ24

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_halted;
        st.halt_bit && (st.mode == peripheral_halt_fast || st.mode == peripheral_halt_slow);
    endsequence

    sequence s_release;
        st.halt_bit && tb_fall && !st.rst_act;
    endsequence

    property p_periph_stop;
        st.halt_bit |-> !periph_clk_en_o && time_base_clk_en_o && cpu_hold_o;
    endproperty
    a_periph_stop: assert property (p_periph_stop) else $error("peripheral clock in halt"); // RQ1

    property p_freeze;
        s_halted |=> $stable({st.xen, st.xten, st.sysck, st.pre_mode, pc_hold_o});
    endproperty
    a_freeze: assert property (p_freeze) else $error("held state changed in halt"); // RQ2

    property p_pc_hold;
        st.halt_bit && $past(st.halt_bit) |-> $stable(pc_hold_o);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("held pc changed in halt"); // RQ3

    property p_entry;
        enter |=> s_halted ##0 (pc_hold_o == $past(cpu_pc_i) + `LPMCS_PC_STEP);
    endproperty
    a_entry: assert property (p_entry) else $error("halt write did not enter"); // RQ5

    property p_wdt_block;
        sc2_wr_i.wr && w_halt && wdt_irq_i && !st.halt_bit |=> !st.halt_bit;
    endproperty
    a_wdt_block: assert property (p_wdt_block) else $error("halt entered despite watchdog"); // RQ14

    property p_il_set;
        enter && tb_ctrl_i.time_base_enable |=> st.il;
    endproperty
    a_il_set: assert property (p_il_set) else $error("time base latch not set"); // RQ8

    property p_release;
        s_release |=> !st.halt_bit && wake_o && (st.mode == $past(st.pre_mode));
    endproperty
    a_release: assert property (p_release) else $error("release did not restore mode"); // RQ7

    property p_kind;
        s_release |=> (time_base_service_o == $past(st.irq_rel)) &&
            (resume_next_o != time_base_service_o);
    endproperty
    a_kind: assert property (p_kind) else $error("wrong release kind"); // RQ11

    property p_sysrst;
        clk_fault |=> sysclk_rst_o [*8];
    endproperty
    a_sysrst: assert property (p_sysrst) else $error("system clock reset too short"); // RQ21

    property p_sysrst_end;
        sysclk_rst_o && st.rst_cnt == RST_LAST |=> !sysclk_rst_o &&
            status_o.mode == fast_single_clock_mode;
    endproperty
    a_sysrst_end: assert property (p_sysrst_end) else $error("system clock reset overran"); // RQ21

    property p_sync_switch;
        st.sel_low && !st.sysck && !fs_fall && !st.rst_act |=> st.sel_low;
    endproperty
    a_sync_switch: assert property (p_sync_switch) else $error("fast switch before sync"); // RQ19

endmodule

/* rtl/lpmcs_consts.svh */
// constants of the low-power mode and clock switch block
`ifndef LPMCS_CONSTS_SVH
`define LPMCS_CONSTS_SVH

// ==========================================================
// system control two: bit positions
`define LPMCS_SC2_XEN 7
`define LPMCS_SC2_XTEN 6
`define LPMCS_SC2_SYSCK 5
`define LPMCS_SC2_HALT 2

// ==========================================================
// reset values of the control bits
`define LPMCS_RST_XEN 1'b1
`define LPMCS_RST_XTEN 1'b0
`define LPMCS_RST_SYSCK 1'b0

// ==========================================================
// pin sampler: eight time base sources plus the low-frequency clock
`define LPMCS_NSRC 9
`define LPMCS_FS_IDX 8

// ==========================================================
// timing
`define LPMCS_CLK_NS 20
`define LPMCS_FC_KHZ 16000
`define LPMCS_SYSRST_FC 24
`define LPMCS_SYSRST_NS ((`LPMCS_SYSRST_FC * 1000000) / `LPMCS_FC_KHZ)
`define LPMCS_SYSRST_CYC (`LPMCS_SYSRST_NS / `LPMCS_CLK_NS)
`define LPMCS_PC_STEP 16'h0002

`endif

/* rtl/lpmcs_pkg.sv */
// types of the low-power mode and clock switch block
package lpmcs_pkg;

    // ==========================================================
    // operating modes, one-hot
    typedef enum logic [5:0] {
        fast_single_clock_mode = 6'h01,
        fast_dual_clock_mode = 6'h02,
        slow_hf_on_mode = 6'h04,
        slow_hf_off_mode = 6'h08,
        peripheral_halt_fast = 6'h10,
        peripheral_halt_slow = 6'h20
    } lpmcs_mode_t;

    // ==========================================================
    // software write to system control two
    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } lpmcs_sc2_wr_t;

    // time base control and interrupt enables
    typedef struct packed {
        logic time_base_enable;
        logic [2:0] time_base_clock_select;
        logic interrupt_master_flag;
        logic time_base_irq_enable;
    } lpmcs_tb_ctrl_t;

    // observable status
    typedef struct packed {
        lpmcs_mode_t mode;
        logic sys_clk_low;
        logic hf_osc_en;
        logic lf_osc_en;
        logic timing_generator_halt;
        logic time_base_interrupt;
    } lpmcs_status_t;

    // pin sampler state
    typedef struct packed {
        logic [8:0] s1;
        logic [8:0] s2;
        logic [8:0] s3;
        logic [8:0] fall;
    } lpmcs_sync_t;

endpackage

/* rtl/lpmcs_pin_sync.sv */
// three-flop sampler with falling-edge pulse for the clock pins
`timescale 1ns/1ps
`include "lpmcs_consts.svh"

module lpmcs_pin_sync (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // pins
    input wire logic [`LPMCS_NSRC-1:0] pin_i,
    // one-cycle falling-edge pulses
    output logic [`LPMCS_NSRC-1:0] fall_o
);
    import lpmcs_pkg::*;

    lpmcs_sync_t st;
    lpmcs_sync_t next_st;
    logic [`LPMCS_NSRC-1:0] fall_d;

    // ==========================================================
    // s1 feeds only s2; edges are found between s2 and s3
    genvar g;
    generate
        for (g = 0; g < `LPMCS_NSRC; g = g + 1) begin : g_edge
            assign fall_d[g] = st.s3[g] & ~st.s2[g];
        end
    endgenerate

    always_comb begin
        next_st = st;
        next_st.s1 = pin_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.fall = fall_d;
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fall_o = st.fall;

endmodule

/* tb/test_lpmcs_core.sv */
// self-checking bench of the low-power mode and clock switch block
`timescale 1ns/1ps
`include "lpmcs_consts.svh"

module test_lpmcs_core;
    import lpmcs_pkg::*;

    typedef struct packed {
        logic [7:0] d;
        lpmcs_mode_t m;
        logic low;
    } lpmcs_row_t;

    // ==========================================================
    // stimulus and observed signals
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    lpmcs_sc2_wr_t sc2 = '0;
    lpmcs_tb_ctrl_t tbc = '0;
    logic wdt = 1'b0;
    logic il_clr = 1'b0;
    logic [15:0] pc = 16'h0000;
    logic [7:0] src = 8'hFF;
    logic fs = 1'b1;
    logic periph_en, base_clk_en, hold, wake, resume, service, srst;
    logic [15:0] pc_hold;
    lpmcs_status_t st;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    lpmcs_row_t rows [4] = '{'{8'hC0, fast_dual_clock_mode, 1'b0},
        '{8'hE0, slow_hf_on_mode, 1'b1}, '{8'h60, slow_hf_off_mode, 1'b1},
        '{8'hE0, slow_hf_on_mode, 1'b1}};
    logic [2:0] kinds [3] = '{3'b111, 3'b101, 3'b011};
    logic [7:0] f_setup [3] = '{8'hC0, 8'hE0, 8'hC0};
    logic [7:0] f_data [3] = '{8'h40, 8'hA0, 8'h00};

    lpmcs_core i_lpmcs_core (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sc2_wr_i(sc2), .tb_ctrl_i(tbc),
        .wdt_irq_i(wdt), .time_base_latch_clr_i(il_clr), .cpu_pc_i(pc),
        .time_base_src_i(src), .fs_clk_i(fs), .periph_clk_en_o(periph_en),
        .time_base_clk_en_o(base_clk_en), .cpu_hold_o(hold), .pc_hold_o(pc_hold),
        .wake_o(wake), .resume_next_o(resume), .time_base_service_o(service),
        .sysclk_rst_o(srst), .status_o(st)
    );

    // ==========================================================
    // clock and timeout
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            complete_run();
        end
    end

    // ==========================================================
    // helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask

    task automatic wr(input logic [7:0] d);
        sc2 = '{wr: 1'b1, data: d};
        tick(1);
        sc2.wr = 1'b0;
        tick(1);
    endtask

    task automatic chk_mode(input lpmcs_mode_t m);
        check("mode", 16'(st.mode), 16'(m));
    endtask

    // waits a bounded time for the release pulse
    task automatic wait_wake(output logic got);
        got = 1'b0;
        for (int i = 0; i < 12 && !got; i++) begin
            tick(1);
            got = (wake === 1'b1);
        end
    endtask

    task automatic halt(input logic [7:0] d, input lpmcs_mode_t hm, input lpmcs_mode_t back,
                        input logic irq);
        logic got;
        pc = 16'h1234;
        wr(d);
        chk_mode(hm);
        check("halt_bit", 16'(st.timing_generator_halt), 16'h0001);
        check("periph_en", 16'(periph_en), 16'h0000);
        check("base_clk_en", 16'(base_clk_en), 16'h0001);
        check("hold", 16'(hold), 16'h0001);
        check("pc_hold", pc_hold, 16'h1236);
        check("latch", 16'(st.time_base_interrupt), 16'(tbc.time_base_enable));
        // a pin that is not selected must not wake
        src = 8'hEF;
        wait_wake(got);
        check("early_wake", 16'(got), 16'h0000);
        src = 8'hE7;
        wait_wake(got);
        check("wake", 16'(got), 16'h0001);
        check("resume", 16'(resume), 16'(!irq));
        check("service", 16'(service), 16'(irq));
        tick(1);
        chk_mode(back);
        check("halt_bit", 16'(st.timing_generator_halt), 16'h0000);
        check("hold", 16'(hold), 16'h0000);
        check("periph_en", 16'(periph_en), 16'h0001);
        src = 8'hFF;
    endtask

    task automatic clr_latch();
        il_clr = 1'b1;
        tick(1);
        il_clr = 1'b0;
        tick(1);
        check("latch_clr", 16'(st.time_base_interrupt), 16'h0000);
    endtask

    task automatic complete_run();
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        int n;
        tick(4);
        sys_rst_i = 1'b0;
        tick(1);
        chk_mode(fast_single_clock_mode);
        check("hf_en", 16'(st.hf_osc_en), 16'h0001);
        check("lf_en", 16'(st.lf_osc_en), 16'h0000);
        check("periph_en", 16'(periph_en), 16'h0001);
        check("pc_hold", pc_hold, 16'h0000);
        foreach (rows[i]) begin
            wr(rows[i].d);
            chk_mode(rows[i].m);
            check("clk_low", 16'(st.sys_clk_low), 16'(rows[i].low));
        end
        // halt from slow with interrupt release
        tbc = '{1'b1, 3'h3, 1'b1, 1'b1};
        halt(8'hE4, peripheral_halt_slow, slow_hf_on_mode, 1'b1);
        clr_latch();
        // return to fast waits for a low-frequency falling edge
        wr(8'hC0);
        tick(3);
        check("clk_low_wait", 16'(st.sys_clk_low), 16'h0001);
        fs = 1'b0;
        for (int i = 0; i < 10 && st.sys_clk_low !== 1'b0; i++) begin
            tick(1);
        end
        check("clk_low", 16'(st.sys_clk_low), 16'h0000);
        chk_mode(fast_dual_clock_mode);
        fs = 1'b1;
        foreach (kinds[i]) begin
            tbc = '{kinds[i][2], 3'h3, kinds[i][1], kinds[i][0]};
            halt(8'hC4, peripheral_halt_fast, fast_dual_clock_mode, &kinds[i]);
            clr_latch();
        end
        // watchdog interrupt at entry blocks the halt
        wdt = 1'b1;
        wr(8'hC4);
        wdt = 1'b0;
        chk_mode(fast_dual_clock_mode);
        check("hold", 16'(hold), 16'h0000);
        foreach (f_data[i]) begin
            wr(f_setup[i]);
            n = 0;
            sc2 = '{wr: 1'b1, data: f_data[i]};
            tick(1);
            sc2.wr = 1'b0;
            repeat (200) begin
                n += int'(srst === 1'b1);
                tick(1);
            end
            check("rst_len", 16'(n), 16'(`LPMCS_SYSRST_CYC));
            chk_mode(fast_single_clock_mode);
            check("hf_en", 16'(st.hf_osc_en), 16'h0001);
        end
        // reset pin releases halt and slow
        foreach (f_setup[i]) begin
            wr(8'hC0);
            wr(i == 0 ? 8'hC4 : 8'hE0);
            sys_rst_i = 1'b1;
            tick(1);
            sys_rst_i = 1'b0;
            tick(1);
            chk_mode(fast_single_clock_mode);
            check("hold", 16'(hold), 16'h0000);
        end
        complete_run();
    end
endmodule
